// ---- sim/nfc_initiator_model.sv ----
// Behavioural remote initiator: sends frames, collects target replies.
// Assumes the framer side shares the target clock.
`timescale 1ns/100ps
`default_nettype none
module nfc_initiator_model (
	input wire clk_i,
	input wire tx_valid_i,
	input wire [7:0] tx_data_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_last_o,
	output logic rx_active_o,
	output logic [1:0] rx_rate_o,
	output logic tx_ready_o
);
	logic [7:0] got[$];
	int slow = 2;
	int wcnt = 0;
	initial begin
		rx_valid_o = 1'h0;
		rx_data_o = 8'h00;
		rx_last_o = 1'h0;
		rx_active_o = 1'h0;
		rx_rate_o = 2'h0;
		tx_ready_o = 1'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One frame, a byte a cycle; idle line shows the inverse of the last byte
	task automatic send(input logic [7:0] b[$], input logic act, input logic [1:0] rate);
		repeat (3) @(negedge clk_i);
		foreach (b[i]) begin
			rx_valid_o = 1'h1;
			rx_data_o = b[i];
			rx_last_o = (i == b.size() - 1);
			rx_active_o = act;
			rx_rate_o = rate;
			@(negedge clk_i);
		end
		rx_valid_o = 1'h0;
		rx_last_o = 1'h0;
		rx_data_o = ~rx_data_o;
	endtask
	// Slow acceptance so the target must hold each byte
	always @(negedge clk_i) begin
		if (tx_ready_o || !tx_valid_i) begin
			tx_ready_o <= 1'h0;
			wcnt <= 0;
		end else if (wcnt >= slow) tx_ready_o <= 1'h1;
		else wcnt <= wcnt + 1;
	end
	// Collect every reply byte taken
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
	end
endmodule
`default_nettype wire

// ---- sim/nfc_target_activation_bench.sv ----
// Self-checking bench: host commands, initiator frames, replies.
// Assumes the checker is bound to the design.
`timescale 1ns/100ps
`default_nettype none
module nfc_target_activation_bench;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic hv = 1'h0;
	logic [7:0] hd = 8'h00;
	logic hl = 1'h0;
	logic htr = 1'h0;
	logic aflag = 1'h1;
	wire rxv, rxl, rxa, txr, hrr, htv, htl, rtv, rtl, pof, dof, cpo, sye;
	wire [7:0] rxd, htd, rtd, amo;
	wire [1:0] rxr, tso;
	logic [7:0] p[0:33];
	logic [7:0] hq[$];
	logic [7:0] atr[$];
	logic [7:0] e[$];
	int error_cnt = 0;
	int compares = 0;
	int err_n = 0;
	always #5 clk = ~clk;
	nfc_target_activation dut (.ref_clk_i(clk), .sys_rst_i(rst), .host_rx_valid_i(hv),
		.host_rx_data_i(hd), .host_rx_last_i(hl), .host_rx_ready_o(hrr),
		.host_tx_valid_o(htv), .host_tx_data_o(htd), .host_tx_last_o(htl),
		.host_tx_ready_i(htr), .rf_rx_valid_i(rxv), .rf_rx_data_i(rxd),
		.rf_rx_last_i(rxl), .rf_rx_active_i(rxa), .rf_rx_rate_i(rxr),
		.rf_tx_valid_o(rtv), .rf_tx_data_o(rtd), .rf_tx_last_o(rtl), .rf_tx_ready_i(txr),
		.auto_attribute_reply_flag_i(aflag), .passive_only_flag_o(pof),
		.dep_only_flag_o(dof), .cmd_pending_o(cpo), .activated_mode_o(amo),
		.target_state_o(tso), .syntax_error_o(sye));
	nfc_initiator_model ini (.clk_i(clk), .tx_valid_i(rtv), .tx_data_i(rtd),
		.rx_valid_o(rxv), .rx_data_o(rxd), .rx_last_o(rxl), .rx_active_o(rxa),
		.rx_rate_o(rxr), .tx_ready_o(txr));
	// Count refusal pulses seen
	always @(posedge clk) begin
		if (sye === 1'h1) err_n++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Host command out of hq, each byte held until taken
	task automatic host_send();
		foreach (hq[i]) begin
			@(negedge clk);
			hv = 1'h1;
			hd = hq[i];
			hl = (i == hq.size() - 1);
			while (hrr !== 1'h1) @(negedge clk);
		end
		@(negedge clk);
		hv = 1'h0;
		hl = 1'h0;
		hq.delete();
	endtask
	task automatic host_exp(input string nm, input logic [7:0] x[$]);
		logic [7:0] b;
		foreach (x[i]) begin
			do @(negedge clk); while (htv !== 1'h1);
			b = htd;
			check("hl", htl, i == x.size() - 1);
			htr = 1'h1;
			@(negedge clk);
			htr = 0;
			check(nm, b, x[i]);
		end
	endtask
	// Initiator-side reply compared, then cleared
	task automatic rf_exp(input string nm, input logic [7:0] x[$]);
		repeat (400) if (ini.got.size() < x.size()) @(posedge clk);
		foreach (x[i]) check(nm, ini.got[i], x[i]);
		ini.got.delete();
	endtask
	task automatic cfg(input logic [7:0] mode, input int lg, input int lt, input bit cut);
		hq = {8'hd4, 8'h8c, mode};
		foreach (p[i]) hq.push_back(p[i]);
		hq.push_back(8'(lg));
		repeat (lg) hq.push_back(8'h60);
		if (!cut) hq.push_back(8'(lt));
		repeat (lt) hq.push_back(8'h61);
		host_send();
	endtask
	task automatic coll106();
		ini.send({8'h26}, 1'h0, 2'h0);
		rf_exp("sens", {p[0], p[1]});
		ini.send({8'h93, 8'h20}, 1'h0, 2'h0);
		rf_exp("uid", {8'h08, p[2], p[3], p[4], 8'h08 ^ p[2] ^ p[3] ^ p[4]});
		ini.send({8'h93, 8'h70, 8'h08, p[2], p[3], p[4], 8'h08 ^ p[2] ^ p[3] ^ p[4]},
			1'h0, 2'h0);
		rf_exp("sel", {p[5]});
	endtask
	// Hang guard, far past the run
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		foreach (p[i]) p[i] = 8'h10 + 8'(i);
		atr = {8'hd4, 8'h00};
		repeat (10) atr.push_back(8'hc5);
		atr = {atr, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		check("ready", hrr, 8'h01);
		check("state", tso, 8'h00);
		cfg(8'h00, 48, 0, 0);
		host_exp("gerr", {8'h7f});
		cfg(8'h00, 0, 49, 0);
		host_exp("terr", {8'h7f});
		cfg(8'h00, 2, 0, 1);
		host_exp("lerr", {8'h7f});
		// Longest legal lengths, sleep restart, plain first frame
		cfg(8'h00, 47, 48, 0);
		coll106();
		ini.send({8'h50, 8'h00}, 1'h0, 2'h0);
		repeat (20) @(posedge clk);
		check("slp", cpo, 8'h01);
		coll106();
		ini.send({8'ha5, 8'h5a}, 1'h0, 2'h0);
		host_exp("rep106", {8'hd5, 8'h8d, 8'h00, 8'ha5, 8'h5a});
		check("errs", 8'(err_n), 8'h03);
		// Passive only: active attempt ignored, then high-rate poll
		cfg(8'h01, 0, 0, 0);
		ini.send(atr, 1'h1, 2'h0);
		repeat (20) @(posedge clk);
		check("pflag", pof, 8'h01);
		check("pact", cpo, 8'h01);
		ini.send({8'h00, 8'hff, 8'hff, 8'h01, 8'h00}, 1'h0, 2'h1);
		e = {8'h01};
		for (int k = 6; k < 24; k++) e.push_back(p[k]);
		rf_exp("pol", e);
		ini.send({8'hb7, 8'h7b}, 1'h0, 2'h1);
		host_exp("rephi", {8'hd5, 8'h8d, 8'h12, 8'hb7, 8'h7b});
		// DEP only, active, reply withheld until general bytes arrive
		aflag = 1'h0;
		cfg(8'h02, 0, 0, 0);
		ini.send({8'hc3, 8'h3c}, 1'h1, 2'h2);
		repeat (20) @(posedge clk);
		check("dflag", dof, 8'h01);
		check("dplain", cpo, 8'h01);
		ini.send(atr, 1'h1, 2'h2);
		host_exp("repatr", {8'hd5, 8'h8d, 8'h25, atr});
		check("held", 8'(ini.got.size()), 8'h00);
		hq = {8'hd4, 8'h92, 8'haa, 8'hbb};
		host_send();
		host_exp("gb", {8'hd5, 8'h93, 8'h00});
		e = {8'hd5, 8'h01};
		for (int k = 24; k < 34; k++) e.push_back(p[k]);
		rf_exp("atrres", {e, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h32, 8'haa, 8'hbb});
		// Control frames answered without the host
		e = {8'h04, 8'h08, 8'h02, 8'h0a};
		foreach (e[i]) begin
			ini.send({8'hd4, e[i], 8'h00}, 1'h1, 2'h2);
			rf_exp("ctl", {8'hd5, e[i] + 8'h01});
			check("tstate", tso, i == 1 ? 8'h02 : i == 3 ? 8'h03 : 8'h01);
		end
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- sim/nfc_target_activation_chk.sv ----
// Port checker for the target activation handler.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module nfc_target_activation_chk (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire host_rx_ready_o,
	input wire host_tx_valid_o,
	input wire [7:0] host_tx_data_o,
	input wire host_tx_ready_i,
	input wire rf_rx_valid_i,
	input wire rf_rx_last_i,
	input wire rf_rx_active_i,
	input wire rf_tx_valid_o,
	input wire [7:0] rf_tx_data_o,
	input wire rf_tx_ready_i,
	input wire passive_only_flag_o,
	input wire cmd_pending_o,
	input wire [7:0] activated_mode_o,
	input wire syntax_error_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////////////////////
	// Error flag is a pulse and is followed by the short refusal reply
	chk_err_pulse: assert property (syntax_error_o |=> !syntax_error_o)
		else $error("error flag held");
	chk_err_reply: assert property ($rose(syntax_error_o) |->
		##[0:6] (host_tx_valid_o && host_tx_data_o == 8'h7f))
		else $error("no refusal reply");
	// Reserved mode bits stay clear; type A framing only at the base rate
	chk_mode_fields: assert property (activated_mode_o[7] == 1'h0 &&
		activated_mode_o[3] == 1'h0 && activated_mode_o[6:4] < 3'h3 &&
		activated_mode_o[1:0] != 2'h3 && (activated_mode_o[1:0] != 2'h0 ||
		activated_mode_o[6:4] == 3'h0)) else $error("bad mode byte");
	// Host port stays closed while the configure command is outstanding
	chk_pending_busy: assert property (cmd_pending_o |-> !host_rx_ready_o)
		else $error("host taken while pending");
	chk_report_head: assert property ($fell(cmd_pending_o) |->
		##[0:4] (host_tx_valid_o && host_tx_data_o == 8'hd5))
		else $error("report missing");
	// Active frames never end a passive-only command
	chk_passive_refuse: assert property (passive_only_flag_o && cmd_pending_o &&
		rf_rx_valid_i && rf_rx_last_i && rf_rx_active_i |=> cmd_pending_o [*8])
		else $error("active activation taken");
	// Offered bytes stand until taken
	chk_host_hold: assert property (host_tx_valid_o && !host_tx_ready_i |=>
		host_tx_valid_o && $stable(host_tx_data_o)) else $error("host byte dropped");
	chk_rf_hold: assert property (rf_tx_valid_o && !rf_tx_ready_i |=>
		rf_tx_valid_o && $stable(rf_tx_data_o)) else $error("rf byte dropped");
endmodule
bind nfc_target_activation nfc_target_activation_chk u_chk (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .host_rx_ready_o(host_rx_ready_o),
	.host_tx_valid_o(host_tx_valid_o), .host_tx_data_o(host_tx_data_o),
	.host_tx_ready_i(host_tx_ready_i), .rf_rx_valid_i(rf_rx_valid_i),
	.rf_rx_last_i(rf_rx_last_i), .rf_rx_active_i(rf_rx_active_i),
	.rf_tx_valid_o(rf_tx_valid_o), .rf_tx_data_o(rf_tx_data_o),
	.rf_tx_ready_i(rf_tx_ready_i), .passive_only_flag_o(passive_only_flag_o),
	.cmd_pending_o(cmd_pending_o), .activated_mode_o(activated_mode_o),
	.syntax_error_o(syntax_error_o));
`default_nettype wire

// ---- src/byte_memory.v ----
// Byte memory for target parameters and the first initiator frame.
// Assumes one writer per cycle; read data is registered.
`timescale 1ns/100ps
`default_nettype none
module byte_memory (
	input wire ref_clk_i,
	input wire wr_en_i,
	input wire [7:0] wr_addr_i,
	input wire [7:0] wr_data_i,
	input wire [7:0] rd_addr_i,
	output reg [7:0] rd_data_o
);
	reg [7:0] mem [0:255];

	// Registered read keeps the transmit path timing clean
	always @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule
`default_nettype wire

// ---- src/frame_classifier.v ----
// Decodes the first two bytes of an initiator frame into a kind.
// Assumes frames arrive without length byte, CRC already checked.
`include "nfc_target_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module frame_classifier (
	input wire [7:0] first_i,
	input wire [7:0] second_i,
	input wire high_rate_i,
	output reg [3:0] kind_o
);
	// Protocol frames first; poll code only means poll at high rate
	always @* begin
		kind_o = `FR_OTHER;
		if (first_i == `RF_DEP_REQ) begin
			case (second_i)
			`RF_ATR_REQ: kind_o = `FR_ATR;
			`RF_PSL: kind_o = `FR_PSL;
			`RF_DSL: kind_o = `FR_DSL;
			`RF_RLS: kind_o = `FR_RLS;
			`RF_WUP: kind_o = `FR_WUP;
			default: kind_o = `FR_OTHER;
			endcase
		end else if (high_rate_i) begin
			if (first_i == `RF_POL)
				kind_o = `FR_POL;
		end else if (first_i == `RF_SENS || first_i == `RF_ALL) begin
			kind_o = `FR_SENS;
		end else if (first_i == `RF_SEL_CL1 && second_i == `RF_SDD_NVB) begin
			kind_o = `FR_SDD;
		end else if (first_i == `RF_SEL_CL1 && second_i == `RF_SEL_NVB) begin
			kind_o = `FR_SEL;
		end else if (first_i == `RF_SLP) begin
			kind_o = `FR_SLP;
		end
	end
endmodule
`default_nettype wire

// ---- src/nfc_target_activation.v ----
// Target activation handler: host command parsing, automatic
// collision replies, activation report and DEP control answers.
// Assumes a same-clock RF framer that delivers checked frames.
`include "nfc_target_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module nfc_target_activation (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire host_rx_valid_i,
	input wire [7:0] host_rx_data_i,
	input wire host_rx_last_i,
	output wire host_rx_ready_o,
	output wire host_tx_valid_o,
	output wire [7:0] host_tx_data_o,
	output wire host_tx_last_o,
	input wire host_tx_ready_i,
	input wire rf_rx_valid_i,
	input wire [7:0] rf_rx_data_i,
	input wire rf_rx_last_i,
	input wire rf_rx_active_i,
	input wire [1:0] rf_rx_rate_i,
	output wire rf_tx_valid_o,
	output wire [7:0] rf_tx_data_o,
	output wire rf_tx_last_o,
	input wire rf_tx_ready_i,
	input wire auto_attribute_reply_flag_i,
	output reg passive_only_flag_o,
	output reg dep_only_flag_o,
	output reg cmd_pending_o,
	output reg [7:0] activated_mode_o,
	output reg [1:0] target_state_o,
	output reg syntax_error_o
);
	localparam S_IDLE = 4'h0, S_CHECK = 4'h1, S_COLL = 4'h2, S_DECIDE = 4'h3;
	localparam S_TX = 4'h4, S_RPT = 4'h5, S_WAIT_GB = 4'h6, S_ACTIVE = 4'h7;
	localparam S_ATR = 4'h8;
	localparam P_H0 = 4'h0, P_H1 = 4'h1, P_MODE = 4'h2, P_PAR = 4'h3;
	localparam P_LGT = 4'h4, P_GT = 4'h5, P_LTK = 4'h6, P_TK = 4'h7;
	localparam P_DONE = 4'h8, P_SGB = 4'h9;
	localparam K_SENS = 4'h0, K_SDD = 4'h1, K_SEL = 4'h2, K_POL = 4'h3;
	localparam K_ATR = 4'h4, K_CTRL = 4'h5, K_RPT = 4'h6, K_GBACK = 4'h7;
	localparam K_ERR = 4'h8;
	localparam T_FETCH = 2'h0, T_SHOW = 2'h1, T_WAIT = 2'h2;

	reg [3:0] st;
	reg [3:0] ph;
	reg [7:0] cnt;
	reg [7:0] op;
	reg [1:0] mode_new;
	reg [7:0] historical_bytes_length;
	reg [7:0] gb_len;
	reg [7:0] gb_new;
	reg syn_err;
	reg from_wait;
	reg from_active;
	reg [63:0] id2;
	reg [7:0] bcc;
	reg [7:0] ridx;
	reg [7:0] rx_len;
	reg [7:0] b0;
	reg [7:0] b1;
	reg [7:0] b3;
	reg rx_act;
	reg [1:0] rx_rate;
	reg id_ok;
	reg [1:0] coll_ph;
	reg sc_req;
	reg activated;
	reg dep_act;
	reg need_gb;
	reg [7:0] ctrl_code;
	reg [3:0] tx_kind;
	reg tx_host;
	reg [3:0] tx_next;
	reg [7:0] tx_idx;
	reg [1:0] tx_ph;
	reg tx_valid;
	reg tx_last;
	reg [7:0] tx_data;
	reg [3:0] next_ph;
	reg byte_err;
	reg par_wr;
	reg [7:0] par_addr;
	reg [7:0] tx_len;
	reg src_mem;
	reg [7:0] src_const;
	reg [7:0] src_addr;
	wire [7:0] mem_q;
	wire [3:0] fk;
	wire host_hs;
	wire rf_wr;
	wire tx_ready;
	wire [7:0] rid_exp;

	// Pick one byte of the stored second identifier
	function [7:0] sel_byte;
		input [63:0] v;
		input [2:0] k;
		begin
			sel_byte = v[{k, 3'b000} +: 8];
		end
	endfunction

	// Host is held off while a command is pending or an RF frame flows
	assign host_rx_ready_o = (st == S_IDLE || st == S_WAIT_GB ||
		(st == S_ACTIVE && ridx == 8'h00 && !rf_rx_valid_i));
	assign host_hs = host_rx_valid_i && host_rx_ready_o;
	assign rf_wr = (st == S_COLL) && rf_rx_valid_i && (ridx < `RX_MAX);
	assign tx_ready = tx_host ? host_tx_ready_i : rf_tx_ready_i;
	assign host_tx_valid_o = tx_valid && tx_host;
	assign rf_tx_valid_o = tx_valid && !tx_host;
	assign host_tx_data_o = tx_data;
	assign rf_tx_data_o = tx_data;
	assign host_tx_last_o = tx_last;
	assign rf_tx_last_o = tx_last;
	assign rid_exp = (ridx < 8'h0a) ? sel_byte(id2, ridx[2:0] - 3'h2) : 8'h00;

	byte_memory mem_u (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(par_wr || rf_wr),
		.wr_addr_i(rf_wr ? (`A_RXBUF + ridx) : par_addr),
		.wr_data_i(rf_wr ? rf_rx_data_i : host_rx_data_i),
		.rd_addr_i(src_addr),
		.rd_data_o(mem_q)
	);

	frame_classifier cls_u (
		.first_i(b0),
		.second_i(b1),
		.high_rate_i(rx_rate != 2'h0),
		.kind_o(fk)
	);

	////////////////////////////////////////////////////////////////////
	// Host command parser, one byte per handshake
	always @* begin
		next_ph = ph;
		byte_err = 1'b0;
		par_wr = 1'b0;
		par_addr = 8'h00;
		case (ph)
		P_H0: begin
			byte_err = (host_rx_data_i != `CMD_PFX_IN);
			next_ph = P_H1;
		end
		P_H1: begin
			if (host_rx_data_i == `CMD_CFG) begin
				next_ph = P_MODE;
			end else if (host_rx_data_i == `CMD_SETGB) begin
				next_ph = P_SGB;
			end else begin
				byte_err = 1'b1;
				next_ph = P_DONE;
			end
		end
		P_MODE: next_ph = P_PAR;
		P_PAR: begin
			par_wr = 1'b1;
			par_addr = cnt;
			if (cnt == `PARAM_LAST)
				next_ph = P_LGT;
		end
		P_LGT: begin
			byte_err = (host_rx_data_i > `GB_MAX);
			next_ph = (host_rx_data_i == 8'h00) ? P_LTK : P_GT;
		end
		P_GT: begin
			par_wr = (cnt < `GB_MAX);
			par_addr = `A_GB + cnt;
			if (cnt == gb_new - 8'h01)
				next_ph = P_LTK;
		end
		P_LTK: begin
			byte_err = (host_rx_data_i > `HB_MAX);
			next_ph = (host_rx_data_i == 8'h00) ? P_DONE : P_TK;
		end
		P_TK: begin
			if (cnt == historical_bytes_length - 8'h01)
				next_ph = P_DONE;
		end
		P_SGB: begin
			byte_err = (cnt >= `GB_MAX);
			par_wr = (cnt < `GB_MAX);
			par_addr = `A_GB + cnt;
		end
		default: byte_err = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Transmit byte source per response kind
	always @* begin
		tx_len = 8'h01;
		src_mem = 1'b0;
		src_const = 8'h00;
		src_addr = 8'h00;
		case (tx_kind)
		K_SENS: begin
			tx_len = 8'h02;
			src_mem = 1'b1;
			src_addr = `A_SENS + tx_idx;
		end
		K_SDD: begin
			tx_len = 8'h05;
			src_mem = (tx_idx != 8'h00 && tx_idx != 8'h04);
			src_const = (tx_idx == 8'h00) ? `UID_CT : bcc;
			src_addr = `A_UID + tx_idx - 8'h01;
		end
		K_SEL: begin
			src_mem = 1'b1;
			src_addr = `A_SEL;
		end
		K_POL: begin
			tx_len = sc_req ? 8'h13 : 8'h11;
			src_mem = (tx_idx != 8'h00);
			src_const = `POL_RES_CODE;
			src_addr = `A_HR + tx_idx - 8'h01;
		end
		K_ATR: begin
			tx_len = 8'h11 + gb_len;
			src_mem = (tx_idx >= 8'h02 && tx_idx < 8'h0c) || tx_idx >= 8'h11;
			src_addr = (tx_idx >= 8'h11) ? (`A_GB + tx_idx - 8'h11) :
				(`A_ID3 + tx_idx - 8'h02);
			case (tx_idx)
			8'h00: src_const = `CMD_PFX_OUT;
			8'h01: src_const = `RF_ATR_RES;
			8'h0f: src_const = `ATR_TO;
			8'h10: src_const = (gb_len != 8'h00) ? `ATR_PP_GB : `ATR_PP_NOGB;
			default: src_const = 8'h00;
			endcase
		end
		K_CTRL: begin
			tx_len = 8'h02;
			src_const = (tx_idx == 8'h00) ? `CMD_PFX_OUT : ctrl_code;
		end
		K_RPT: begin
			tx_len = 8'h03 + rx_len;
			src_mem = (tx_idx >= 8'h03);
			src_addr = `A_RXBUF + tx_idx - 8'h03;
			case (tx_idx)
			8'h00: src_const = `CMD_PFX_OUT;
			8'h01: src_const = `RSP_CFG;
			default: src_const = activated_mode_o;
			endcase
		end
		K_GBACK: begin
			tx_len = 8'h03;
			case (tx_idx)
			8'h00: src_const = `CMD_PFX_OUT;
			8'h01: src_const = `RSP_SETGB;
			default: src_const = `STATUS_OK;
			endcase
		end
		K_ERR: src_const = `RSP_SYNERR;
		default: src_const = 8'h00;
		endcase
	end

	// Launch a response frame toward host or initiator
	task start_tx;
		input [3:0] k;
		input h;
		input [3:0] nxt;
		begin
			tx_kind <= k;
			tx_host <= h;
			tx_next <= nxt;
			tx_idx <= 8'h00;
			tx_ph <= T_FETCH;
			st <= S_TX;
		end
	endtask

	// Mark activation and build the reported mode byte
	task activate;
		input [1:0] framing;
		input dep;
		input atr;
		begin
			activated_mode_o <= {2'b00, rx_act ? rx_rate :
				(framing == `FRAMING_TYPEA ? 2'h0 : rx_rate), 1'b0, dep, framing};
			activated <= 1'b1;
			dep_act <= dep;
			target_state_o <= `TS_ACTIVATED;
			need_gb <= atr && !auto_attribute_reply_flag_i;
			if (atr && auto_attribute_reply_flag_i)
				start_tx(K_ATR, 1'b0, S_RPT);
			else
				st <= S_RPT;
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequencer
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st <= S_IDLE;
			ph <= P_H0;
			cnt <= 8'h00;
			op <= 8'h00;
			mode_new <= 2'h0;
			historical_bytes_length <= 8'h00;
			gb_len <= 8'h00;
			gb_new <= 8'h00;
			syn_err <= 1'b0;
			from_wait <= 1'b0;
			from_active <= 1'b0;
			id2 <= 64'h0;
			bcc <= 8'h00;
			ridx <= 8'h00;
			rx_len <= 8'h00;
			b0 <= 8'h00;
			b1 <= 8'h00;
			b3 <= 8'h00;
			rx_act <= 1'b0;
			rx_rate <= 2'h0;
			id_ok <= 1'b0;
			coll_ph <= 2'h0;
			sc_req <= 1'b0;
			activated <= 1'b0;
			dep_act <= 1'b0;
			need_gb <= 1'b0;
			ctrl_code <= 8'h00;
			tx_kind <= K_ERR;
			tx_host <= 1'b1;
			tx_next <= S_IDLE;
			tx_idx <= 8'h00;
			tx_ph <= T_FETCH;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
			tx_data <= 8'h00;
			passive_only_flag_o <= 1'b0;
			dep_only_flag_o <= 1'b0;
			cmd_pending_o <= 1'b0;
			activated_mode_o <= 8'h00;
			target_state_o <= `TS_IDLE;
			syntax_error_o <= 1'b0;
		end else begin
			syntax_error_o <= 1'b0;
			// Host bytes: field capture and length tracking
			if (host_hs) begin
				ph <= host_rx_last_i ? P_H0 : next_ph;
				syn_err <= (ph == P_H0 ? 1'b0 : syn_err) | byte_err;
				cnt <= (next_ph != ph) ? 8'h00 : cnt + 8'h01;
				case (ph)
				P_H1: op <= host_rx_data_i;
				P_MODE: begin
					mode_new <= host_rx_data_i[1:0];
					bcc <= `UID_CT;
				end
				P_PAR: begin
					if (cnt >= `A_HR && cnt <= `A_HR_ID_END)
						id2 <= {host_rx_data_i, id2[63:8]};
					if (cnt >= `A_UID && cnt < `A_SEL)
						bcc <= bcc ^ host_rx_data_i;
				end
				P_LGT: gb_new <= host_rx_data_i;
				P_LTK: historical_bytes_length <= host_rx_data_i;
				P_SGB: gb_new <= cnt + 8'h01;
				default: op <= op;
				endcase
				if (ph == P_H1 && host_rx_data_i == `CMD_SETGB)
					gb_new <= 8'h00;
				if (host_rx_last_i) begin
					// A command ending early or late is a length error
					if (!(next_ph == P_DONE || next_ph == P_SGB))
						syn_err <= 1'b1;
					from_wait <= (st == S_WAIT_GB);
					from_active <= (st == S_ACTIVE);
					st <= S_CHECK;
				end
			end

			// RF bytes: first-frame buffer and identifier compare
			if ((st == S_COLL || st == S_ACTIVE) && rf_rx_valid_i) begin
				if (ridx == 8'h00)
					b0 <= rf_rx_data_i;
				if (ridx == 8'h01)
					b1 <= rf_rx_data_i;
				if (ridx == 8'h03)
					b3 <= rf_rx_data_i;
				if (ridx == 8'h00)
					id_ok <= 1'b1;
				else if (ridx >= 8'h02 && ridx < 8'h0c && rf_rx_data_i != rid_exp)
					id_ok <= 1'b0;
				if (ridx != 8'hff)
					ridx <= ridx + 8'h01;
				if (rf_rx_last_i) begin
					rx_len <= (ridx < `RX_MAX) ? ridx + 8'h01 : `RX_MAX;
					rx_act <= rf_rx_active_i;
					rx_rate <= rf_rx_rate_i;
					ridx <= 8'h00;
					st <= S_DECIDE;
				end
			end else if (st != S_COLL && st != S_ACTIVE) begin
				ridx <= 8'h00;
			end

			case (st)
			S_CHECK: begin
				if (syn_err) begin
					syntax_error_o <= 1'b1;
					start_tx(K_ERR, 1'b1, from_wait ? S_WAIT_GB :
						(from_active ? S_ACTIVE : S_IDLE));
				end else if (op == `CMD_CFG) begin
					passive_only_flag_o <= mode_new[`MODE_PASSIVE_BIT];
					dep_only_flag_o <= mode_new[`MODE_DEP_BIT];
					gb_len <= gb_new;
					cmd_pending_o <= 1'b1;
					activated <= 1'b0;
					target_state_o <= `TS_IDLE;
					coll_ph <= 2'h0;
					st <= S_COLL;
				end else if (from_wait) begin
					gb_len <= gb_new;
					start_tx(K_GBACK, 1'b1, S_ATR);
				end else begin
					syntax_error_o <= 1'b1;
					start_tx(K_ERR, 1'b1, from_active ? S_ACTIVE : S_IDLE);
				end
			end
			S_DECIDE: begin
				st <= activated ? S_ACTIVE : S_COLL;
				if (activated) begin
					if (dep_act) begin
						case (fk)
						`FR_PSL: begin
							ctrl_code <= `RF_PSL + 8'h01;
							start_tx(K_CTRL, 1'b0, S_ACTIVE);
						end
						`FR_DSL: begin
							ctrl_code <= `RF_DSL + 8'h01;
							target_state_o <= `TS_DESELECTED;
							start_tx(K_CTRL, 1'b0, S_ACTIVE);
						end
						`FR_RLS: begin
							ctrl_code <= `RF_RLS + 8'h01;
							target_state_o <= `TS_RELEASED;
							start_tx(K_CTRL, 1'b0, S_ACTIVE);
						end
						`FR_WUP: begin
							ctrl_code <= `RF_WUP + 8'h01;
							target_state_o <= `TS_ACTIVATED;
							start_tx(K_CTRL, 1'b0, S_ACTIVE);
						end
						default: st <= S_ACTIVE;
						endcase
					end
				end else if (rx_act) begin
					// Active framing: only an attribute request activates
					if (passive_only_flag_o)
						coll_ph <= 2'h0;
					else if (fk == `FR_ATR)
						activate(`FRAMING_ACTIVE, 1'b1, 1'b1);
					else
						coll_ph <= 2'h0;
				end else if (rx_rate == 2'h0) begin
					if (coll_ph == 2'h3 && fk != `FR_SENS) begin
						if (fk == `FR_ATR)
							activate(`FRAMING_TYPEA, 1'b1, 1'b1);
						else if (fk == `FR_SLP || dep_only_flag_o)
							coll_ph <= 2'h0;
						else
							activate(`FRAMING_TYPEA, 1'b0, 1'b0);
					end else if (fk == `FR_SENS) begin
						coll_ph <= 2'h1;
						start_tx(K_SENS, 1'b0, S_COLL);
					end else if (fk == `FR_SDD && coll_ph != 2'h0) begin
						coll_ph <= 2'h2;
						start_tx(K_SDD, 1'b0, S_COLL);
					end else if (fk == `FR_SEL && coll_ph == 2'h2) begin
						coll_ph <= 2'h3;
						start_tx(K_SEL, 1'b0, S_COLL);
					end
				end else begin
					if (fk == `FR_POL) begin
						coll_ph <= 2'h3;
						sc_req <= (b3 == `RF_POL_SC);
						start_tx(K_POL, 1'b0, S_COLL);
					end else if (coll_ph == 2'h3) begin
						if (fk == `FR_ATR && id_ok)
							activate(`FRAMING_HIGH, 1'b1, 1'b1);
						else if (fk == `FR_ATR || dep_only_flag_o)
							coll_ph <= 2'h0;
						else
							activate(`FRAMING_HIGH, 1'b0, 1'b0);
					end
				end
			end
			S_RPT: begin
				cmd_pending_o <= 1'b0;
				start_tx(K_RPT, 1'b1, need_gb ? S_WAIT_GB : S_ACTIVE);
			end
			S_ATR: start_tx(K_ATR, 1'b0, S_ACTIVE);
			S_TX: begin
				// Three cycles per byte: address, registered data, handshake
				case (tx_ph)
				T_FETCH: tx_ph <= T_SHOW;
				T_SHOW: begin
					tx_data <= src_mem ? mem_q : src_const;
					tx_valid <= 1'b1;
					tx_last <= (tx_idx == tx_len - 8'h01);
					tx_ph <= T_WAIT;
				end
				default: begin
					if (tx_ready) begin
						tx_valid <= 1'b0;
						tx_last <= 1'b0;
						tx_idx <= tx_idx + 8'h01;
						tx_ph <= T_FETCH;
						if (tx_last)
							st <= tx_next;
					end
				end
				endcase
			end
			default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- src/nfc_target_consts.vh ----
// Shared constants of the contactless target activation handler.
// Assumes inclusion by bare name; holds definitions only.
// Notes on behaviour
// - Request D4 8C; reply D5 8D, mode, frame
// - Passive-only mode refuses active activation
// - DEP-only rejects plain first frame, restarts
// - Append system code when poll byte four 0x01
// - Third-form identifier goes into attribute reply
// - General-bytes length above 47 is error
// - Historical length above 48, bad length: error
// - Mode byte: rate, DEP flag, framing
// - Report first valid initiator frame to host
// - Store parameters, then run collision sequence
// - 106 passive: sense, anticollision, select replies
// - Attribute reply automatic or after general bytes
// - Sleep request restarts sequence, command pending
// - Plain frame forwarded unless DEP-only set
// - Poll reply; attribute id must match padded
// - Active: rate from frame, else restart
// - Auto-answer select, deselect, release, wake-up
`ifndef NFC_TARGET_CONSTS_VH
`define NFC_TARGET_CONSTS_VH
// Host framing
`define CMD_PFX_IN 8'hd4
`define CMD_PFX_OUT 8'hd5
`define CMD_CFG 8'h8c
`define RSP_CFG 8'h8d
`define CMD_SETGB 8'h92
`define RSP_SETGB 8'h93
`define RSP_SYNERR 8'h7f
`define STATUS_OK 8'h00
// Mode byte fields
`define MODE_PASSIVE_BIT 0
`define MODE_DEP_BIT 1
`define FRAMING_TYPEA 2'h0
`define FRAMING_ACTIVE 2'h1
`define FRAMING_HIGH 2'h2
// Length limits and parameter layout
`define GB_MAX 8'h2f
`define HB_MAX 8'h30
`define PARAM_LAST 8'h21
`define A_SENS 8'h00
`define A_UID 8'h02
`define A_SEL 8'h05
`define A_HR 8'h06
`define A_HR_ID_END 8'h0d
`define A_ID3 8'h18
`define A_GB 8'h28
`define A_RXBUF 8'h80
`define RX_MAX 8'h7f
// RF request and response codes
`define RF_SENS 8'h26
`define RF_ALL 8'h52
`define RF_SEL_CL1 8'h93
`define RF_SDD_NVB 8'h20
`define RF_SEL_NVB 8'h70
`define RF_SLP 8'h50
`define RF_POL 8'h00
`define RF_POL_SC 8'h01
`define RF_DEP_REQ 8'hd4
`define RF_ATR_REQ 8'h00
`define RF_ATR_RES 8'h01
`define RF_WUP 8'h02
`define RF_PSL 8'h04
`define RF_DSL 8'h08
`define RF_RLS 8'h0a
`define UID_CT 8'h08
`define POL_RES_CODE 8'h01
`define ATR_TO 8'h0e
`define ATR_PP_NOGB 8'h30
`define ATR_PP_GB 8'h32
// Classified frame kinds
`define FR_OTHER 4'h0
`define FR_SENS 4'h1
`define FR_SDD 4'h2
`define FR_SEL 4'h3
`define FR_SLP 4'h4
`define FR_POL 4'h5
`define FR_ATR 4'h6
`define FR_PSL 4'h7
`define FR_DSL 4'h8
`define FR_RLS 4'h9
`define FR_WUP 4'ha
// Target states
`define TS_IDLE 2'h0
`define TS_ACTIVATED 2'h1
`define TS_DESELECTED 2'h2
`define TS_RELEASED 2'h3
`endif
